// file: nbw_pkg.sv
package nbw_pkg;

    // ************************************************************
    // register map (apb byte addresses)
    // ************************************************************
    localparam logic [7:0] ADDR_CONTROL = 8'h00;
    localparam logic [7:0] ADDR_UNLOCK  = 8'h04;
    localparam logic [7:0] ADDR_POINTER = 8'h08;
    localparam logic [7:0] ADDR_LATCH   = 8'h0c;
    localparam logic [7:0] ADDR_OP      = 8'h10;
    localparam logic [7:0] ADDR_STATUS  = 8'h14;

    // control field positions
    localparam int CTL_START  = 0;
    localparam int CTL_WRITE_ENABLE_GATE   = 2;
    localparam int CTL_FAULT  = 3;
    localparam int CTL_ERASE  = 4;
    localparam int CTL_REG_LO = 6;
    localparam int CTL_REG_HI = 7;

    // operation register bits
    localparam int OP_READ  = 0;
    localparam int OP_STORE = 1;

    // status register bits
    localparam int ST_STALL = 0;
    localparam int ST_DONE  = 1;
    localparam int ST_LOCK  = 2;

    // ************************************************************
    // reset values and codes
    // ************************************************************
    localparam logic [1:0]  REGION_RST  = 2'h0;
    localparam logic [1:0]  REGION_PFM  = 2'h2;
    localparam logic [7:0]  UNLOCK_KEY1 = 8'h55;
    localparam logic [7:0]  UNLOCK_KEY2 = 8'haa;
    localparam logic [7:0]  HOLD_RST    = 8'hff;
    localparam logic [21:0] PTR_RST     = 22'h000000;

    // ************************************************************
    // id and configuration windows
    // ************************************************************
    localparam logic [21:0] UID_LO = 22'h200000;
    localparam logic [21:0] UID_HI = 22'h20000f;
    localparam logic [21:0] CFG_LO = 22'h300000;
    localparam logic [21:0] CFG_HI = 22'h30000b;
    localparam logic [21:0] DID_LO = 22'h3ffffc;
    localparam logic [21:0] DID_HI = 22'h3fffff;

    // ************************************************************
    // timing
    // ************************************************************
    localparam int CLK_HZ          = 50_000_000;
    localparam int PROG_TIME_US    = 2000;
    localparam int PROG_CYCLES     = CLK_HZ / 1_000_000 * PROG_TIME_US;
    localparam int CFG_TIME_US     = 2000;
    localparam int CFG_CYCLES      = CLK_HZ / 1_000_000 * CFG_TIME_US;
    localparam int ID_READ_CYCLES  = 2;

    typedef enum logic [4:0] {
        NBW_IDLE  = 5'b00001,
        NBW_PROG  = 5'b00010,
        NBW_CFGW  = 5'b00100,
        NBW_IDRD  = 5'b01000,
        NBW_DONE  = 5'b10000
    } nbw_state_type;

    typedef struct packed {
        logic       we;
        logic [5:0] index;
        logic [7:0] data;
        logic       fill;
    } nbw_hold_req_type;

endpackage

// file: nbw_hold_mem.sv
module nbw_hold_mem
    import nbw_pkg::*;
#(
    parameter int DEPTH = 64
) (
    // clock and reset
    input  wire logic                     clk_sys,
    input  wire logic                     rst_n,
    // request
    input  wire nbw_pkg::nbw_hold_req_type req,
    input  wire logic [$clog2(DEPTH)-1:0] rd_index,
    // read data
    output logic [7:0]                    rd_data
);
    logic [7:0] mem [DEPTH];

    initial begin
        if (DEPTH < 2 || DEPTH > 64) begin
            $error("nbw_hold_mem: depth out of range");
        end
    end

    // fill sets every byte back to erased value
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem[i] <= HOLD_RST;
            end
        end else if (req.fill) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem[i] <= HOLD_RST;
            end
        end else if (req.we) begin
            mem[req.index[$clog2(DEPTH)-1:0]] <= req.data;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rd_data <= HOLD_RST;
        end else begin
            rd_data <= mem[rd_index];
        end
    end
endmodule

// file: nbw_sequencer.sv
// What this block does
// - block write stalls cpu for programming time
// - pin or watchdog reset mid-write sets fault
// - start bit gated by write enable
// - each write needs fresh unlock sequence
// - region 01 or 11 routes id/config access
// - id locations read only, user id and config writable
// - id read loads latch while cpu stalled
// - id read outside ranges clears latch
// - hardware never clears write enable
// - locked or invalid config write faults
// - config byte write self-erases, starts at once
// - config write stalls, sets done, then start clears
// - new config value effective on resume
// - decode user id, config, id windows
// - start set by firmware, cleared by hardware
// - holding registers return to ones after program
// - region 10 selects flash, no direct read
//
// The register offsets and the APB interface to the registers were decided locally.
module nbw_sequencer
    import nbw_pkg::*;
#(
    parameter int HOLD_DEPTH  = 64,
    parameter int PROG_CNT    = PROG_CYCLES,
    parameter int CFG_CNT     = CFG_CYCLES
) (
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        resetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // reset causes seen by the sequencer
    input  wire logic        external_reset_pin_n,
    input  wire logic        watchdog_timer_reset,
    // configuration lock strap
    input  wire logic        config_lock_bit,
    // device identification bytes, low address first
    input  wire logic [31:0] device_id_bytes,
    // cpu and flash side
    output logic             cpu_stall,
    output logic             completion_flag,
    output logic             flash_prog,
    output logic [21:0]      flash_addr,
    output logic [7:0]       config_wdata,
    output logic             config_commit
);
    import nbw_pkg::*;

    localparam int HW = $clog2(HOLD_DEPTH);

    initial begin
        if (PROG_CNT < 1 || CFG_CNT < 1 || HOLD_DEPTH > 64) begin
            $error("nbw_sequencer: bad parameter");
        end
    end

    // ************************************************************
    // reset release
    // ************************************************************
    logic rst_meta;
    logic rst_n;
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // ************************************************************
    // registers and state
    // ************************************************************
    nbw_state_type    state;
    logic             start;
    logic             write_enable_gate;
    logic             fault_flag;
    logic             erase_sel;
    logic [1:0]       region_select;
    logic [1:0]       unlock_step;
    logic [21:0]      table_pointer;
    logic [7:0]       table_latch;
    logic [31:0]      timer;
    logic [7:0]       cfg_store [12];
    logic [7:0]       uid_store [16];
    nbw_hold_req_type hold_req;
    logic [7:0]       hold_rd;
    logic             pend_abort;

    wire logic acc     = psel && penable && pready;
    wire logic wr_acc  = acc && pwrite;
    wire logic rd_acc  = acc && !pwrite;
    wire logic idle    = (state == NBW_IDLE);
    wire logic id_reg  = region_select[0];

    // window decode
    wire logic in_uid = table_pointer >= UID_LO && table_pointer <= UID_HI;
    wire logic in_cfg = table_pointer >= CFG_LO && table_pointer <= CFG_HI;
    wire logic in_did = table_pointer >= DID_LO && table_pointer <= DID_HI;

    // start request: only with write enable and a fresh unlock
    wire logic ctl_wr   = wr_acc && paddr == ADDR_CONTROL && idle;
    wire logic start_rq = ctl_wr && pwdata[CTL_START]
                          && write_enable_gate
                          && unlock_step == 2'd2;
    // config writes need lock bit set and writable address
    wire logic id_bad   = !(in_uid || in_cfg) || (in_cfg && !config_lock_bit);

    // ************************************************************
    // apb answer: one wait state, unmapped reads zero with error
    // ************************************************************
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0;
        end else begin
            pready  <= psel && penable && !pready;
            pslverr <= 1'b0;
            prdata  <= 32'h0;
            if (psel && penable && !pready) begin
                case (paddr)
                    ADDR_CONTROL: prdata <= {24'h0, region_select, 1'b0, erase_sel, fault_flag,
                                             write_enable_gate, 1'b0, start};
                    ADDR_UNLOCK:  prdata <= 32'h0;
                    ADDR_POINTER: prdata <= {10'h0, table_pointer};
                    ADDR_LATCH:   prdata <= {24'h0, table_latch};
                    ADDR_OP:      prdata <= 32'h0;
                    ADDR_STATUS:  prdata <= {29'h0, config_lock_bit, completion_flag,
                                             cpu_stall};
                    default:      pslverr <= 1'b1;
                endcase
            end
        end
    end

    // ************************************************************
    // control bits
    // ************************************************************
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            write_enable_gate <= 1'b0;
            erase_sel         <= 1'b0;
            region_select     <= REGION_RST;
        end else if (ctl_wr) begin
            // only firmware changes write enable
            write_enable_gate <= pwdata[CTL_WRITE_ENABLE_GATE];
            erase_sel         <= pwdata[CTL_ERASE];
            region_select     <= pwdata[CTL_REG_HI:CTL_REG_LO];
        end
    end

    // unlock tracker: 55h then aah, any other access spoils it
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            unlock_step <= 2'd0;
        end else if (wr_acc) begin
            if (paddr == ADDR_UNLOCK && pwdata[7:0] == UNLOCK_KEY1) begin
                unlock_step <= 2'd1;
            end else if (paddr == ADDR_UNLOCK && pwdata[7:0] == UNLOCK_KEY2
                         && unlock_step == 2'd1) begin
                unlock_step <= 2'd2;
            end else begin
                unlock_step <= 2'd0;
            end
        end else if (rd_acc) begin
            unlock_step <= 2'd0;
        end
    end

    // ************************************************************
    // table pointer and latch
    // ************************************************************
    wire logic store_op = wr_acc && paddr == ADDR_OP && pwdata[OP_STORE] && idle;
    wire logic read_op  = wr_acc && paddr == ADDR_OP && pwdata[OP_READ] && idle;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            table_pointer <= PTR_RST;
        end else if (wr_acc && paddr == ADDR_POINTER && idle) begin
            table_pointer <= pwdata[21:0];
        end else if (store_op && !id_reg) begin
            table_pointer <= table_pointer + 22'h1;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            table_latch <= 8'h0;
        end else if (wr_acc && paddr == ADDR_LATCH && idle) begin
            table_latch <= pwdata[7:0];
        end else if (state == NBW_IDRD && timer == 32'h0) begin
            if (in_uid) begin
                table_latch <= uid_store[table_pointer[3:0]];
            end else if (in_cfg) begin
                table_latch <= cfg_store[table_pointer[3:0]];
            end else if (in_did) begin
                table_latch <= device_id_bytes[8*table_pointer[1:0] +: 8];
            end else begin
                table_latch <= 8'h0;
            end
        end else if (read_op && !id_reg) begin
            table_latch <= hold_rd;
        end
    end

    // ************************************************************
    // holding registers
    // ************************************************************
    always_comb begin
        hold_req.we    = store_op && !id_reg;
        hold_req.index = 6'(table_pointer[HW-1:0]);
        hold_req.data  = table_latch;
        hold_req.fill  = (state == NBW_PROG) && timer == 32'h0;
    end

    nbw_hold_mem #(
        .DEPTH (HOLD_DEPTH)
    ) u_hold (
        .clk_sys  (clk_sys),
        .rst_n    (rst_n),
        .req      (hold_req),
        .rd_index (table_pointer[HW-1:0]),
        .rd_data  (hold_rd)
    );

    // ************************************************************
    // sequencer
    // ************************************************************
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state <= NBW_IDLE;
            timer <= 32'h0;
        end else begin
            case (state)
                NBW_IDLE: begin
                    if (start_rq && !id_reg && region_select == REGION_PFM) begin
                        state <= NBW_PROG;
                        timer <= 32'(PROG_CNT - 1);
                    end else if (start_rq && id_reg && !id_bad) begin
                        state <= NBW_CFGW;
                        timer <= 32'(CFG_CNT - 1);
                    end else if (read_op && id_reg) begin
                        state <= NBW_IDRD;
                        timer <= 32'(ID_READ_CYCLES - 1);
                    end
                end
                NBW_PROG, NBW_CFGW, NBW_IDRD: begin
                    if (timer == 32'h0) begin
                        state <= NBW_DONE;
                    end else begin
                        timer <= timer - 32'h1;
                    end
                end
                NBW_DONE: state <= NBW_IDLE;
                default:  state <= NBW_IDLE;
            endcase
        end
    end

    // start flag: set by firmware, cleared only here
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            start <= 1'b0;
        end else if (start_rq && (id_reg ? !id_bad : region_select == REGION_PFM)) begin
            start <= 1'b1;
        end else if (state == NBW_DONE) begin
            start <= 1'b0;
        end
    end

    // stall output, high while any long operation runs
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cpu_stall <= 1'b0;
        end else begin
            cpu_stall <= state == NBW_PROG || state == NBW_CFGW || state == NBW_IDRD;
        end
    end

    // completion flag: set beats firmware clear in the same cycle
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            completion_flag <= 1'b0;
        end else if ((state == NBW_PROG || state == NBW_CFGW) && timer == 32'h0) begin
            completion_flag <= 1'b1;
        end else if (wr_acc && paddr == ADDR_STATUS && pwdata[ST_DONE]) begin
            completion_flag <= 1'b0;
        end
    end

    // no reset here: the catch must survive the very reset it reports,
    // so the cause must be seen one edge before resetn falls
    always_ff @(posedge clk_sys) begin
        if (!external_reset_pin_n || watchdog_timer_reset) begin
            pend_abort <= pend_abort || state == NBW_PROG || state == NBW_CFGW;
        end else if (rst_n) begin
            pend_abort <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            fault_flag <= 1'b0;
        end else if (pend_abort) begin
            fault_flag <= 1'b1;
        end else if (start_rq && id_reg && id_bad) begin
            fault_flag <= 1'b1;
        end else if (ctl_wr && !pwdata[CTL_FAULT]) begin
            fault_flag <= 1'b0;
        end
    end

    // ************************************************************
    // configuration and user id storage
    // ************************************************************
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < 12; i++) begin
                cfg_store[i] <= HOLD_RST;
            end
            for (int i = 0; i < 16; i++) begin
                uid_store[i] <= HOLD_RST;
            end
        end else if (state == NBW_CFGW && timer == 32'h0) begin
            if (in_cfg) begin
                cfg_store[table_pointer[3:0]] <= table_latch;
            end else begin
                uid_store[table_pointer[3:0]] <= table_latch;
            end
        end
    end

    // flash side strobes
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            flash_prog    <= 1'b0;
            flash_addr    <= PTR_RST;
            config_wdata  <= 8'h0;
            config_commit <= 1'b0;
        end else begin
            flash_prog    <= state == NBW_PROG;
            flash_addr    <= table_pointer;
            config_wdata  <= table_latch;
            config_commit <= state == NBW_CFGW && timer == 32'h0 && in_cfg;
        end
    end
endmodule

// file: nbw_sequencer_sva.sv
module nbw_sequencer_sva
    import nbw_pkg::*;
#(
    parameter int PROG_CNT = PROG_CYCLES,
    parameter int CFG_CNT  = CFG_CYCLES
) (
    // clock and reset
    input wire logic        clk_sys,
    input wire logic        resetn,
    // apb
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    // straps and flash side
    input wire logic        config_lock_bit,
    input wire logic        cpu_stall,
    input wire logic        completion_flag,
    input wire logic        flash_prog,
    input wire logic [21:0] flash_addr,
    input wire logic        config_commit
);
    // ************************************************************
    // shadow of firmware side: write enable, unlock progress
    // ************************************************************
    logic        xfer;
    logic        write_enable_gate_sh;
    logic        armed;
    logic [1:0]  stage;
    int unsigned cnt;
    assign xfer = psel && penable && pready;
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn)
            write_enable_gate_sh <= 1'b0;
        else if (xfer && pwrite && paddr == ADDR_CONTROL && !cpu_stall)
            write_enable_gate_sh <= pwdata[CTL_WRITE_ENABLE_GATE];
    end
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn)
            stage <= 2'h0;
        else if (xfer && pwrite && paddr == ADDR_UNLOCK && pwdata[7:0] == UNLOCK_KEY1)
            stage <= 2'h1;
        else if (xfer && pwrite && paddr == ADDR_UNLOCK && pwdata[7:0] == UNLOCK_KEY2)
            stage <= (stage == 2'h1) ? 2'h2 : 2'h0;
        else if (xfer)
            stage <= 2'h0;
    end
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn)
            armed <= 1'b0;
        else if (xfer)
            armed <= pwrite && paddr == ADDR_CONTROL && pwdata[CTL_START] && stage == 2'h2;
    end
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn)
            cnt <= 0;
        else
            cnt <= flash_prog ? cnt + 1 : 0;
    end

    default clocking @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    a_prog_stall: assert property (flash_prog |-> cpu_stall)
        else $error("cpu not stalled during block program");
    a_prog_time: assert property ($fell(flash_prog) |-> cnt >= PROG_CNT - 1 && cnt <= PROG_CNT + 4)
        else $error("block program length wrong");
    a_start_gated: assert property ($rose(flash_prog) |-> write_enable_gate_sh)
        else $error("program began with write enable clear");
    a_fresh_unlock: assert property ($rose(flash_prog) |-> armed)
        else $error("program began without fresh unlock");
    a_cfg_flag: assert property (config_commit |-> ##[0:3] completion_flag)
        else $error("completion flag missing after config write");
    a_cfg_resume: assert property (config_commit |-> $past(cpu_stall) ##[0:1] !cpu_stall)
        else $error("config value not tied to cpu resume");
    a_cfg_window: assert property (config_commit |->
        (flash_addr >= UID_LO && flash_addr <= UID_HI) || (flash_addr >= CFG_LO && flash_addr <= CFG_HI))
        else $error("config write outside writable windows");
    a_cfg_lock: assert property (config_commit && flash_addr >= CFG_LO |-> config_lock_bit)
        else $error("config word written while locked");

    c_prog: cover property ($rose(flash_prog));
    c_cfg: cover property (config_commit);
    c_resume: cover property ($fell(cpu_stall) && completion_flag);
endmodule

bind nbw_sequencer nbw_sequencer_sva #(.PROG_CNT(PROG_CNT), .CFG_CNT(CFG_CNT)) i_sva (
    .clk_sys, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .config_lock_bit,
    .cpu_stall, .completion_flag, .flash_prog, .flash_addr, .config_commit);

// file: nbw_sequencer_tb.sv
module nbw_sequencer_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import nbw_pkg::*;
    localparam int PCNT = 20;
    typedef struct {logic [31:0] d; logic [31:0] m; logic e;} nbw_note_type;
    logic         clk_sys = 1'b0;
    logic         resetn  = 1'b0;
    logic         psel    = 1'b0;
    logic         penable = 1'b0;
    logic         pwrite  = 1'b0;
    logic         pin_n   = 1'b1;
    logic         wdog    = 1'b0;
    logic         lock    = 1'b1;
    logic [7:0]   paddr   = 8'h00;
    logic [31:0]  pwdata  = 32'h0;
    logic [31:0]  dev_id  = 32'h0;
    logic [15:0]  lfsr    = 16'h243f;
    logic [31:0]  prdata;
    logic         pready, pslverr, cpu_stall, completion_flag, flash_prog, config_commit;
    logic [21:0]  flash_addr;
    logic [7:0]   config_wdata;
    logic [7:0]   b [3];
    logic [21:0]  bad [3] = '{UID_HI + 22'h1, CFG_HI + 22'h1, DID_LO - 22'h1};
    nbw_note_type notes[$];
    nbw_note_type nt;
    int           fails = 0;
    int           n_checks = 0;

    nbw_sequencer #(.PROG_CNT(PCNT), .CFG_CNT(PCNT)) i_dut (
        .clk_sys(clk_sys), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .external_reset_pin_n(pin_n), .watchdog_timer_reset(wdog), .config_lock_bit(lock),
        .device_id_bytes(dev_id), .cpu_stall(cpu_stall), .completion_flag(completion_flag),
        .flash_prog(flash_prog), .flash_addr(flash_addr), .config_wdata(config_wdata),
        .config_commit(config_commit));

    always #10 clk_sys = ~clk_sys;

    // ************************************************************
    // bus tasks and checks
    // ************************************************************
    function automatic logic [7:0] rnd();
        lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
        return lfsr[7:0];
    endfunction
    task automatic chk(input logic ok, input string s);
        n_checks++;
        if (ok !== 1'b1) begin
            fails++;
            $display("[ERR] %0t %s", $time, s);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 50);
        chk(n < 50, "no pready");
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    // the note goes in before the request so the monitor never waits on it
    task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m,
                      input logic e = 1'b0);
        notes.push_back('{d, m, e});
        apb(1'b0, a, 32'h0);
    endtask
    task automatic rdb(input logic [21:0] a, input logic [7:0] d);
        wr(ADDR_POINTER, {10'h0, a});
        wr(ADDR_OP, 32'h1);
        idle();
        rd(ADDR_LATCH, {24'h0, d}, 32'hff);
    endtask
    task automatic unl();
        wr(ADDR_UNLOCK, {24'h0, UNLOCK_KEY1});
        wr(ADDR_UNLOCK, {24'h0, UNLOCK_KEY2});
    endtask
    task automatic idle();
        int n = 0;
        repeat (2) @(posedge clk_sys);
        do begin
            @(posedge clk_sys);
            n++;
        end while (cpu_stall !== 1'b0 && n < PCNT + 40);
        chk(n < PCNT + 40, "stall stuck");
    endtask
    task automatic cfgw(input logic [21:0] a, input logic [7:0] d, input logic ok);
        int n = 0;
        wr(ADDR_CONTROL, 32'h44);
        wr(ADDR_POINTER, {10'h0, a});
        wr(ADDR_LATCH, {24'h0, d});
        unl();
        wr(ADDR_CONTROL, 32'h45);
        while (config_commit !== 1'b1 && n < PCNT + 40) begin
            @(posedge clk_sys);
            n++;
        end
        chk((n < PCNT + 40) === ok, "config commit");
        if (ok) chk(config_wdata === d && flash_addr === a, "config data");
        idle();
    endtask
    task automatic rst(input int c);
        resetn <= 1'b0;
        repeat (c) @(posedge clk_sys);
        resetn <= 1'b1;
        pin_n <= 1'b1;
        wdog <= 1'b0;
        repeat (3) @(posedge clk_sys);
    endtask
    task automatic summarize();
        $display("checks %0d fails %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    always @(posedge clk_sys) begin
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            nt = notes.pop_front();
            chk((prdata & nt.m) === (nt.d & nt.m) && pslverr === nt.e, "read mismatch");
        end
    end

    initial begin
        #200000;
        fails++;
        summarize();
    end

    initial begin
        rst(8);
        dev_id <= {rnd(), rnd(), rnd(), rnd()};
        rd(ADDR_CONTROL, 32'h0, 32'hff);
        rd(8'h18, 32'h0, 32'hffffffff, 1'b1);
        rd(ADDR_UNLOCK, 32'h0, 32'hffffffff);
        wr(ADDR_CONTROL, 32'h80);
        unl();
        wr(ADDR_CONTROL, 32'h81);
        rd(ADDR_CONTROL, 32'h80, 32'hff);
        wr(ADDR_CONTROL, 32'h84);
        wr(ADDR_POINTER, 32'h100);
        for (int i = 0; i < 3; i++) begin
            b[i] = rnd();
            wr(ADDR_LATCH, {24'h0, b[i]});
            wr(ADDR_OP, 32'h2);
        end
        rd(ADDR_POINTER, 32'h103, 32'h3fffff);
        rdb(22'h101, b[1]);
        wr(ADDR_POINTER, 32'h101);
        wr(ADDR_UNLOCK, {24'h0, UNLOCK_KEY1});
        rd(ADDR_POINTER, 32'h101, 32'h3fffff);
        wr(ADDR_UNLOCK, {24'h0, UNLOCK_KEY2});
        wr(ADDR_CONTROL, 32'h85);
        rd(ADDR_CONTROL, 32'h84, 32'hff);
        unl();
        wr(ADDR_CONTROL, 32'h85);
        idle();
        rd(ADDR_CONTROL, 32'h84, 32'hdd);
        rd(ADDR_STATUS, 32'h2, 32'h3);
        rdb(22'h101, HOLD_RST);
        wr(ADDR_STATUS, 32'h2);
        rd(ADDR_STATUS, 32'h0, 32'h2);
        wr(ADDR_CONTROL, 32'h85);
        rd(ADDR_CONTROL, 32'h84, 32'hff);
        for (int r = 1; r < 4; r += 2) begin
            wr(ADDR_CONTROL, {24'h0, r[1:0], 6'h0});
            for (int k = 0; k < 4; k++) rdb(DID_LO + k[21:0], dev_id[8*k +: 8]);
            for (int k = 0; k < 3; k++) begin
                wr(ADDR_LATCH, 32'h5a);
                rdb(bad[k], 8'h00);
            end
        end
        b[0] = rnd();
        cfgw(CFG_LO + 22'h2, b[0], 1'b1);
        rd(ADDR_CONTROL, 32'h44, 32'hdd);
        rd(ADDR_STATUS, 32'h2, 32'h2);
        rdb(CFG_LO + 22'h2, b[0]);
        lock <= 1'b0;
        cfgw(CFG_LO + 22'h3, rnd(), 1'b0);
        rd(ADDR_CONTROL, 32'h08, 32'h09);
        b[1] = rnd();
        cfgw(UID_LO + 22'h5, b[1], 1'b0);
        rdb(UID_LO + 22'h5, b[1]);
        cfgw(DID_LO, rnd(), 1'b0);
        rdb(DID_LO, dev_id[7:0]);
        for (int c = 0; c < 2; c++) begin
            wr(ADDR_CONTROL, 32'h84);
            unl();
            wr(ADDR_CONTROL, 32'h85);
            repeat (5) @(posedge clk_sys);
            pin_n <= c[0];
            wdog <= c[0];
            @(posedge clk_sys);
            rst(2);
            rd(ADDR_CONTROL, 32'h08, 32'h08);
        end
        summarize();
    end
endmodule
